/* src/idrs_pkg.sv */
package idrs_pkg;
   // memory geometry
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned RAM_DEPTH  = 256;
   // address map
   localparam logic [7:0]  LOW_HALF_MAX  = 8'h7F;   // direct reaches ram up to here
   localparam logic [7:0]  BIT_AREA_BASE = 8'h20;   // first bit-addressable byte
   localparam logic [7:0]  STACK_PTR_SFR = 8'h81;   // direct address of the pointer
   localparam logic [7:0]  STACK_PTR_RST = 8'h07;   // pointer value after reset
   localparam logic [7:0]  ONE_BYTE      = 8'h01;
   localparam logic [7:0]  TWO_BYTES     = 8'h02;
   localparam int unsigned BANK_LSB      = 3;       // bank select lands at addr bits 4:3
   localparam int unsigned BIT_SHIFT     = 3;       // bit address to byte offset
   // program store geometry and speed limit
   localparam int unsigned PROG_ADDR_W   = 12;      // 4 KB
   localparam int unsigned PROG_DEPTH    = 4096;
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned PROG_MAX_MHZ  = 8;
   localparam int unsigned PROG_DIV      = (CLK_MHZ + PROG_MAX_MHZ - 1) / PROG_MAX_MHZ;
   localparam int unsigned PROG_DIV_W    = 4;
   // operation codes from the core
   typedef enum logic [3:0] {
      IDRS_OP_NONE, IDRS_OP_RD_DIR, IDRS_OP_WR_DIR, IDRS_OP_RD_IND, IDRS_OP_WR_IND,
      IDRS_OP_RD_REG, IDRS_OP_WR_REG, IDRS_OP_RD_BIT, IDRS_OP_WR_BIT,
      IDRS_OP_PUSH, IDRS_OP_POP, IDRS_OP_CALL, IDRS_OP_RET
   } idrs_op_type;
endpackage : idrs_pkg

/* src/idrs_ram.sv */
// Operation
// - provide 256 by 8 bit data ram
// - low half same cell direct or indirect
// - upper half: indirect ram, direct special space
// - lowest 32 bytes: four banks, status selects
// - bytes 20h to 2Fh give 128 bits
// - byte is 20h plus bit/8, low bits
// - bit access touches only the chosen bit
// - reset loads stack pointer with 07h
// - stack grows up, first byte at 08h
// - pointer may address anywhere, no overlap checks
// - push stores one byte, pointer plus one
// - call or interrupt stores two bytes, plus two
// - pop minus one, return reads two, minus two
// - 4 KB program store read at most 8 MHz
// - stack pointer readable writable at any time
`timescale 1ns/1ps
`default_nettype none
module idrs_ram
   import idrs_pkg::*;
(
   // clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   rstn_i,
   // core request
   input  wire idrs_op_type            op_i,
   input  wire logic [ADDR_W-1:0]      addr_i,      // byte, bit, or work register number
   input  wire logic [DATA_W-1:0]      wdata_i,     // byte, or bit in bit 0
   input  wire logic [15:0]            ret_addr_i,  // return address for calls
   input  wire logic [1:0]             bank_sel_i,  // bank_select_high, bank_select_low
   // core answer
   output logic [DATA_W-1:0]           rdata_o,     // byte, or bit in bit 0
   output logic [15:0]                 ret_addr_o,  // popped return address
   output logic                        rvalid_o,    // read data valid, one cycle
   output logic [ADDR_W-1:0]           stack_top_pointer_o,
   // special function space for direct upper accesses
   output logic                        sfs_rd_o,
   output logic                        sfs_wr_o,
   output logic [ADDR_W-1:0]           sfs_addr_o,
   output logic [DATA_W-1:0]           sfs_wdata_o,
   input  wire logic [DATA_W-1:0]      sfs_rdata_i,
   // program store port
   input  wire logic                   prog_req_i,
   input  wire logic [PROG_ADDR_W-1:0] prog_addr_i,
   input  wire logic                   prog_we_i,   // loader write
   input  wire logic [DATA_W-1:0]      prog_wdata_i,
   output logic [DATA_W-1:0]           prog_rdata_o,
   output logic                        prog_ack_o
);
   // internal_data_ram and program_store arrays
   logic [DATA_W-1:0] mem [RAM_DEPTH];
   logic [DATA_W-1:0] prog_mem [PROG_DEPTH];

   // all register state in one struct
   typedef struct packed {
      logic [ADDR_W-1:0]      sp;        // stack_top_pointer
      logic [DATA_W-1:0]      rdata;
      logic [15:0]            ret;
      logic                   rvalid;
      logic                   sfs_rd;
      logic                   sfs_wr;
      logic [ADDR_W-1:0]      sfs_addr;
      logic [DATA_W-1:0]      sfs_wdata;
      logic                   sfs_pend;   // sfr read answer due next cycle
      logic [PROG_DIV_W-1:0]  pdiv;       // program store pacing counter
      logic                   pbusy;
      logic [PROG_ADDR_W-1:0] paddr;
      logic [DATA_W-1:0]      prdata;
      logic                   pack;
   } idrs_state_type;

   idrs_state_type st_r;
   idrs_state_type st_nxt;

   // memory write controls, at most two bytes per cycle
   logic              we0;
   logic              we1;
   logic [ADDR_W-1:0] wa0;
   logic [ADDR_W-1:0] wa1;
   logic [DATA_W-1:0] wd0;
   logic [DATA_W-1:0] wd1;

   // decoded helpers
   logic [ADDR_W-1:0] reg_addr;   // work register byte address
   logic [ADDR_W-1:0] bit_byte;   // byte holding an addressed bit
   logic [2:0]        bit_pos;
   logic              upper;

   // work register and bit address decode
   always_comb begin
      reg_addr = {3'b000, bank_sel_i, addr_i[2:0]};
      bit_byte = BIT_AREA_BASE + (addr_i >> BIT_SHIFT);
      bit_pos  = addr_i[2:0];
      upper    = (addr_i > LOW_HALF_MAX);
   end

   // next-state and memory write selection
   always_comb begin
      st_nxt        = st_r;
      st_nxt.rvalid = 1'b0;
      st_nxt.sfs_rd = 1'b0;
      st_nxt.sfs_wr = 1'b0;
      st_nxt.pack   = 1'b0;
      we0 = 1'b0;
      we1 = 1'b0;
      wa0 = addr_i;
      wa1 = addr_i;
      wd0 = wdata_i;
      wd1 = wdata_i;
      // sfr read answer returns one cycle after the strobe
      st_nxt.sfs_pend = 1'b0;
      if (st_r.sfs_pend) begin
         st_nxt.rdata  = sfs_rdata_i;
         st_nxt.rvalid = 1'b1;
      end
      unique case (op_i)
         IDRS_OP_NONE: begin
            // idle
         end
         IDRS_OP_RD_DIR: begin
            if (!upper) begin
               st_nxt.rdata  = mem[addr_i];
               st_nxt.rvalid = 1'b1;
            end else if (addr_i == STACK_PTR_SFR) begin
               st_nxt.rdata  = st_r.sp;
               st_nxt.rvalid = 1'b1;
            end else begin
               st_nxt.sfs_rd   = 1'b1;
               st_nxt.sfs_addr = addr_i;
               st_nxt.sfs_pend = 1'b1;
            end
         end
         IDRS_OP_WR_DIR: begin
            if (!upper) begin
               we0 = 1'b1;
            end else if (addr_i == STACK_PTR_SFR) begin
               st_nxt.sp = wdata_i;
            end else begin
               st_nxt.sfs_wr    = 1'b1;
               st_nxt.sfs_addr  = addr_i;
               st_nxt.sfs_wdata = wdata_i;
            end
         end
         IDRS_OP_RD_IND: begin
            st_nxt.rdata  = mem[addr_i];
            st_nxt.rvalid = 1'b1;
         end
         IDRS_OP_WR_IND: begin
            we0 = 1'b1;
         end
         IDRS_OP_RD_REG: begin
            st_nxt.rdata  = mem[reg_addr];
            st_nxt.rvalid = 1'b1;
         end
         IDRS_OP_WR_REG: begin
            we0 = 1'b1;
            wa0 = reg_addr;
         end
         IDRS_OP_RD_BIT: begin
            // only the low bit area is handled here
            st_nxt.rdata  = {7'b000_0000, mem[bit_byte][bit_pos]};
            st_nxt.rvalid = 1'b1;
         end
         IDRS_OP_WR_BIT: begin
            // read-modify-write keeps the other seven bits
            we0 = 1'b1;
            wa0 = bit_byte;
            wd0 = mem[bit_byte];
            wd0[bit_pos] = wdata_i[0];
         end
         IDRS_OP_PUSH: begin
            // pointer moves first, byte lands at the new top
            wa0 = st_r.sp + ONE_BYTE;
            we0 = 1'b1;
            st_nxt.sp = st_r.sp + ONE_BYTE;
         end
         IDRS_OP_POP: begin
            st_nxt.rdata  = mem[st_r.sp];
            st_nxt.rvalid = 1'b1;
            st_nxt.sp     = st_r.sp - ONE_BYTE;
         end
         IDRS_OP_CALL: begin
            // low byte first, then high byte, wraps freely
            we0 = 1'b1;
            wa0 = st_r.sp + ONE_BYTE;
            wd0 = ret_addr_i[7:0];
            we1 = 1'b1;
            wa1 = st_r.sp + TWO_BYTES;
            wd1 = ret_addr_i[15:8];
            st_nxt.sp = st_r.sp + TWO_BYTES;
         end
         IDRS_OP_RET: begin
            st_nxt.ret    = {mem[st_r.sp], mem[st_r.sp - ONE_BYTE]};
            st_nxt.rvalid = 1'b1;
            st_nxt.sp     = st_r.sp - TWO_BYTES;
         end
         default: begin
            // unused operation codes do nothing
         end
      endcase
      // program store: one read per divider period, keeps reads at 8 MHz or less
      if (st_r.pbusy) begin
         if (st_r.pdiv == PROG_DIV_W'(PROG_DIV - 1)) begin
            st_nxt.pbusy  = 1'b0;
            st_nxt.pdiv   = '0;
            st_nxt.prdata = prog_mem[st_r.paddr];
            st_nxt.pack   = 1'b1;
         end else begin
            st_nxt.pdiv = st_r.pdiv + 1'b1;
         end
      end else if (prog_req_i && !prog_we_i) begin
         st_nxt.pbusy = 1'b1;
         st_nxt.paddr = prog_addr_i;
      end
   end

   // state register with synchronous reset
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         st_r    <= '0;
         st_r.sp <= STACK_PTR_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // memory arrays hold no reset, contents are undefined at power up
   always_ff @(posedge ref_clk_i) begin
      if (we0) begin
         mem[wa0] <= wd0;
      end
      if (we1) begin
         mem[wa1] <= wd1;
      end
      if (prog_we_i && prog_req_i && !st_r.pbusy) begin
         prog_mem[prog_addr_i] <= prog_wdata_i;
      end
   end

   // outputs straight from flops
   assign rdata_o             = st_r.rdata;
   assign ret_addr_o          = st_r.ret;
   assign rvalid_o            = st_r.rvalid;
   assign stack_top_pointer_o = st_r.sp;
   assign sfs_rd_o            = st_r.sfs_rd;
   assign sfs_wr_o            = st_r.sfs_wr;
   assign sfs_addr_o          = st_r.sfs_addr;
   assign sfs_wdata_o         = st_r.sfs_wdata;
   assign prog_rdata_o        = st_r.prdata;
   assign prog_ack_o          = st_r.pack;
endmodule : idrs_ram
`default_nettype wire

/* sim/idrs_ram_props.sv */
`timescale 1ns/1ps
`default_nettype none
module idrs_ram_props
   import idrs_pkg::*;
(
   // clock and reset
   input wire logic              ref_clk_i,
   input wire logic              rstn_i,
   // core side
   input wire idrs_op_type       op_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic              rvalid_o,
   input wire logic [ADDR_W-1:0] stack_top_pointer_o,
   // special space side
   input wire logic              sfs_rd_o,
   input wire logic              sfs_wr_o,
   input wire logic [ADDR_W-1:0] sfs_addr_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // pointer moves by the exact stack cost of each op
   chk_push_step: assert property (op_i == IDRS_OP_PUSH |=>
      stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01) else $error("push step");
   chk_call_step: assert property (op_i == IDRS_OP_CALL |=>
      stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h02) else $error("call step");
   chk_pop_step: assert property (op_i == IDRS_OP_POP |=> rvalid_o &&
      stack_top_pointer_o == $past(stack_top_pointer_o) - 8'h01) else $error("pop step");
   chk_ret_step: assert property (op_i == IDRS_OP_RET |=> rvalid_o &&
      stack_top_pointer_o == $past(stack_top_pointer_o) - 8'h02) else $error("ret step");
   // reset value must show even while reset is still low
   chk_reset_ptr: assert property (disable iff (1'b0) !rstn_i |=>
      stack_top_pointer_o == 8'h07) else $error("pointer reset value");
   // upper direct other than 81h goes out, indirect never does
   chk_upper_dir: assert property (op_i == IDRS_OP_RD_DIR && addr_i[7]
      && addr_i != 8'h81 |=> sfs_rd_o && sfs_addr_o == $past(addr_i)) else $error("sfs read");
   chk_ind_local: assert property ((op_i == IDRS_OP_RD_IND || op_i == IDRS_OP_WR_IND)
      |=> !sfs_rd_o && !sfs_wr_o) else $error("indirect left ram");
   chk_low_dir: assert property (op_i == IDRS_OP_RD_DIR && !addr_i[7]
      |=> rvalid_o && !sfs_rd_o) else $error("low direct read");
   chk_bit_only: assert property (op_i == IDRS_OP_RD_BIT
      |=> rvalid_o && rdata_o[7:1] == 7'h00) else $error("bit read width");
endmodule : idrs_ram_props
`default_nettype wire

/* sim/idrs_sfs_model.sv */
`timescale 1ns/1ps
`default_nettype none
module idrs_sfs_model
   import idrs_pkg::*;
(
   // clock
   input  wire logic              ref_clk_i,
   // request from the block
   input  wire logic              sfs_rd_i,
   input  wire logic [ADDR_W-1:0] sfs_addr_i,
   // answer
   output logic [DATA_W-1:0]      sfs_rdata_o
);
   logic [DATA_W-1:0] junk_r; // churns so a stale answer never matches
   // free running filler while not addressed
   // plain always: the initial value below would be a second writer for always_ff
   always @(posedge ref_clk_i) begin
      junk_r <= junk_r + 8'h3B;
   end
   // answer is a fixed scramble of the address
   assign sfs_rdata_o = sfs_rd_i ? (sfs_addr_i ^ 8'h5A) : junk_r;
   initial junk_r = 8'h00;
endmodule : idrs_sfs_model
`default_nettype wire

/* sim/tb_internal_data_ram_and_stack.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_internal_data_ram_and_stack;
   import idrs_pkg::*;
   // stimulus
   logic clk = 0, rstn = 0, prog_req = 0, prog_we = 0;
   idrs_op_type op = IDRS_OP_NONE;
   logic [7:0] addr = 0, wdata = 0, prog_wdata = 0, rdata, sp_o, sfs_a, sfs_d, sfs_q, prog_q;
   logic [15:0] ret_in = 0, ret_out;
   logic [1:0] bank = 0;
   logic [11:0] prog_addr = 0;
   logic rvalid, sfs_rd, sfs_wr, prog_ack;
   // reference state
   logic [7:0] mem [256], sp, a, d;
   integer seed = 32'ha51c, bad_count = 0, checked = 0, i, n;
   always #5 clk = ~clk;
   idrs_ram dut_u (.ref_clk_i(clk), .rstn_i(rstn), .op_i(op), .addr_i(addr), .wdata_i(wdata),
      .ret_addr_i(ret_in), .bank_sel_i(bank), .rdata_o(rdata), .ret_addr_o(ret_out),
      .rvalid_o(rvalid), .stack_top_pointer_o(sp_o), .sfs_rd_o(sfs_rd), .sfs_wr_o(sfs_wr),
      .sfs_addr_o(sfs_a), .sfs_wdata_o(sfs_d), .sfs_rdata_i(sfs_q), .prog_req_i(prog_req),
      .prog_addr_i(prog_addr), .prog_we_i(prog_we), .prog_wdata_i(prog_wdata),
      .prog_rdata_o(prog_q), .prog_ack_o(prog_ack));
   idrs_sfs_model sfs_u (.ref_clk_i(clk), .sfs_rd_i(sfs_rd), .sfs_addr_i(sfs_a),
      .sfs_rdata_o(sfs_q));
   // one op for one cycle, outputs settled on return
   task automatic run(input idrs_op_type o, input logic [7:0] x, input logic [7:0] v);
      @(posedge clk) begin op <= o; addr <= x; wdata <= v; end
      @(posedge clk) op <= IDRS_OP_NONE;
      #1;
   endtask : run
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      #1 sp = 8'h07;
      `CHK(sp_o, sp)
      for (i = 0; i < 3; i++) begin // stack grows from 08h
         d = $random(seed);
         run(IDRS_OP_PUSH, 0, d);
         sp++;
         mem[sp] = d;
         `CHK(sp_o, sp)
      end
      run(IDRS_OP_RD_IND, 8'h08, 0);
      `CHK(rdata, mem[8])
      @(posedge clk) ret_in <= $random(seed);
      run(IDRS_OP_CALL, 0, 0);
      sp += 2;
      `CHK(sp_o, sp)
      run(IDRS_OP_RET, 0, 0);
      `CHK(ret_out, ret_in)
      sp -= 2;
      run(IDRS_OP_POP, 0, 0);
      `CHK(rdata, mem[sp])
      sp--;
      $display("stack ops done");
      for (i = 0; i < 24; i++) begin // low half, then upper half
         a = (i < 16) ? ($random(seed) & 8'h7F) : ($random(seed) | 8'h80);
         if (a == 8'h81) a = 8'h82;
         d = $random(seed);
         run((i < 16) ? IDRS_OP_WR_DIR : IDRS_OP_WR_IND, a, d);
         mem[a] = d;
         if (a[7]) begin
            run(IDRS_OP_WR_DIR, a, ~d); // must stay in special space
            `CHK(sfs_wr, 1'b1)
            `CHK(sfs_a, a)
            `CHK(sfs_d, ~d)
         end
         run(IDRS_OP_RD_IND, a, 0);
         `CHK(rdata, mem[a])
         if (a[7]) begin
            run(IDRS_OP_RD_DIR, a, 0);
            @(posedge clk) #1;
            `CHK(rdata, a ^ 8'h5A)
         end
      end
      $display("map done");
      for (i = 0; i < 4; i++) begin // each bank of work registers
         @(posedge clk) bank <= i[1:0];
         a = {3'b000, i[1:0], 3'(($random(seed)))};
         d = $random(seed);
         run(IDRS_OP_WR_REG, {5'h00, a[2:0]}, d);
         run(IDRS_OP_RD_DIR, a, 0);
         `CHK(rdata, d)
      end
      for (i = 0; i < 8; i++) begin // bit area, bit addresses 42h and 7Fh first
         a = (i == 0) ? 8'h42 : (i == 1) ? 8'h7F : ($random(seed) & 8'h7F);
         d = {7'h00, i[0]};
         run(IDRS_OP_WR_BIT, a, d);
         mem[8'h20 + (a >> 3)][a[2:0]] = d[0];
         run(IDRS_OP_RD_DIR, 8'h20 + (a >> 3), 0);
         `CHK(rdata, mem[8'h20 + (a >> 3)])
         run(IDRS_OP_RD_BIT, a, 0);
         `CHK(rdata, d)
      end
      $display("banks and bits done");
      run(IDRS_OP_WR_DIR, 8'h81, 8'hBF);
      d = $random(seed);
      run(IDRS_OP_PUSH, 0, d);
      run(IDRS_OP_RD_IND, 8'hC0, 0);
      `CHK(rdata, d)
      run(IDRS_OP_RD_DIR, 8'h81, 0);
      `CHK(rdata, 8'hC0)
      $display("pointer reload done");
      d = $random(seed);
      @(posedge clk) begin prog_req <= 1; prog_we <= 1; prog_addr <= 12'hFFF; prog_wdata <= d; end
      @(posedge clk) begin prog_req <= 0; prog_we <= 0; end
      @(posedge clk) prog_req <= 1;
      @(posedge clk) prog_req <= 0;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (prog_ack !== 1'b1 && n < 40);
      `CHK(prog_q, d)
      `CHK(n, PROG_DIV)
      $display("program store done");
      print_verdict();
   end
endmodule : tb_internal_data_ram_and_stack
bind idrs_ram idrs_ram_props u_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .op_i(op_i),
   .addr_i(addr_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sfs_addr_o(sfs_addr_o),
   .stack_top_pointer_o(stack_top_pointer_o), .sfs_rd_o(sfs_rd_o), .sfs_wr_o(sfs_wr_o));
`default_nettype wire
